// [inc/stt_consts.svh]
// constants for the system tick timer: offsets, fields, reset values, timing
`ifndef STT_CONSTS_SVH
`define STT_CONSTS_SVH
`define STT_ADDR_W 4
`define STT_OFS_CTRL 4'h0
`define STT_OFS_RELOAD 4'h4
`define STT_OFS_CURRENT 4'h8
`define STT_OFS_CALIB 4'hC
`define STT_BIT_ENABLE 0
`define STT_BIT_TICK_IRQ_ENABLE 1
`define STT_BIT_CLKSEL 2
`define STT_BIT_ZFLAG 16
`define STT_CNT_W 24
`define STT_CTRL_RESET 3'h0
`define STT_RELOAD_RESET 24'h000000
`define STT_CURRENT_RESET 24'h000000
`define STT_REF_DIV 16'h0004
`endif

// [inc/stt_pkg.sv]
// types for the system tick timer
`default_nettype none
package stt_pkg;
    typedef logic [23:0] stt_count_t;
    typedef enum {STT_IDLE, STT_RUN, STT_HALT} stt_state_t;
endpackage
`default_nettype wire

// [core/stt_ref_tick.sv]
// reference tick divider producing a one-cycle enable pulse
`default_nettype none
`include "stt_consts.svh"
module stt_ref_tick #(
    parameter logic [15:0] DIV = `STT_REF_DIV
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic extTick,
    input wire logic useCore,
    output logic tick
);
    import stt_pkg::*;
    logic [15:0] divCnt;
    // divided reference, passes the external tick only in one cycle of every DIV
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            divCnt <= 16'h0000;
        end else if (divCnt >= DIV - 16'h0001) begin
            divCnt <= 16'h0000;
        end else begin
            divCnt <= divCnt + 16'h0001;
        end
    end
    // core clock gives a pulse every cycle
    assign tick = useCore ? 1'b1 : (extTick & (divCnt == 16'h0000));
endmodule
`default_nettype wire

// [core/stt_regs_rd.sv]
// read-data mux for the tick timer registers
`default_nettype none
`include "stt_consts.svh"
module stt_regs_rd (
    input wire logic mclk,
    input wire logic rst,
    input wire logic rdStb,
    input wire logic [`STT_ADDR_W-1:0] addr,
    input wire logic [2:0] ctrl,
    input wire logic zeroFlag,
    input wire stt_pkg::stt_count_t reloadVal,
    input wire stt_pkg::stt_count_t curVal,
    output logic [31:0] rdData
);
    import stt_pkg::*;
    // registered read data, unmapped reads return zero
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rdData <= 32'h00000000;
        end else if (rdStb) begin
            case (addr)
                `STT_OFS_CTRL: rdData <= {15'h0000, zeroFlag, 13'h0000, ctrl};
                `STT_OFS_RELOAD: rdData <= {8'h00, reloadVal};
                `STT_OFS_CURRENT: rdData <= {8'h00, curVal};
                default: rdData <= 32'h00000000;
            endcase
        end else begin
            rdData <= 32'h00000000;
        end
    end
endmodule
`default_nettype wire

// [core/stt_timer.sv]
// system tick timer: 24-bit down counter with control, reload and current registers
//
// Our own choices: strobed register access and the placing of the registers.
`default_nettype none
`include "stt_consts.svh"
// Functional notes
// - 24-bit down counter wrapping at zero, cleared by software write
// - counts reload value down to zero, reloads on next edge
// - zero reload value stops the counter at its next wrap
// - zero-reached flag set whenever the count arrives at zero
// - reading control/status clears the zero-reached flag
// - any write to current count zeroes it and clears the flag
// - clearing through current-count write never pends a tick
// - current-count read returns the count at access time
// - count holds while the core is halted in debug
// - counting clock is core clock or external reference
// - control selects clock, enables counter and tick, shows status
// - bit 0 enables repeated reload-and-count operation
// - bit 1 makes arrival at zero pend the tick exception
// - bit 2 selects clock: 0 external reference, 1 core clock
// - wrap value N of 1 or more gives one tick every N+1 counting pulses
module stt_timer (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [`STT_ADDR_W-1:0] addr,
    input wire logic [31:0] wrData,
    input wire logic wrStb,
    input wire logic rdStb,
    output logic [31:0] rdData,
    input wire logic debugHalt,
    input wire logic extRefTick,
    output logic tickPend
);
    import stt_pkg::*;

    // ==========================================
    // registers
    logic [2:0] ctrl;
    logic zeroFlag;
    stt_count_t reloadVal;
    stt_count_t curVal;
    logic refTick;
    logic step;
    logic hitZero;
    logic wrCtrl;
    logic wrReload;
    logic wrCur;
    logic rdCtrl;

    assign wrCtrl = wrStb && addr == `STT_OFS_CTRL;
    assign wrReload = wrStb && addr == `STT_OFS_RELOAD;
    assign wrCur = wrStb && addr == `STT_OFS_CURRENT;
    assign rdCtrl = rdStb && addr == `STT_OFS_CTRL;

    // control bits: enable, tick enable, clock select
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ctrl <= `STT_CTRL_RESET;
        end else if (wrCtrl) begin
            ctrl <= wrData[2:0];
        end
    end

    // reload value register
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            reloadVal <= `STT_RELOAD_RESET;
        end else if (wrReload) begin
            reloadVal <= wrData[`STT_CNT_W-1:0];
        end
    end

    // ==========================================
    // counting clock
    stt_ref_tick u_ref (
        .mclk(mclk),
        .rst(rst),
        .extTick(extRefTick),
        .useCore(ctrl[`STT_BIT_CLKSEL]),
        .tick(refTick)
    );

    // a step happens only when enabled, not halted, on a reference pulse
    assign step = ctrl[`STT_BIT_ENABLE] && !debugHalt && refTick;
    // arrival at zero is the step from one to zero
    assign hitZero = step && curVal == 24'h000001;

    // ==========================================
    // counter
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            curVal <= `STT_CURRENT_RESET;
        end else if (wrCur) begin
            curVal <= 24'h000000;
        end else if (step) begin
            if (curVal == 24'h000000) begin
                curVal <= reloadVal;
            end else begin
                curVal <= curVal - 24'h000001;
            end
        end
    end

    // sticky zero flag; set wins over read clear, write clear wins over set
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            zeroFlag <= 1'b0;
        end else if (hitZero && !wrCur) begin
            zeroFlag <= 1'b1;
        end else if (rdCtrl || wrCur) begin
            zeroFlag <= 1'b0;
        end
    end

    // tick pend pulse
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            tickPend <= 1'b0;
        end else begin
            tickPend <= hitZero && !wrCur && ctrl[`STT_BIT_TICK_IRQ_ENABLE];
        end
    end

    // ==========================================
    // read path
    stt_regs_rd u_rd (
        .mclk(mclk),
        .rst(rst),
        .rdStb(rdStb),
        .addr(addr),
        .ctrl(ctrl),
        .zeroFlag(zeroFlag),
        .reloadVal(reloadVal),
        .curVal(curVal),
        .rdData(rdData)
    );

    // ==========================================
    // checks
    a_write_clears: assert property (@(posedge mclk) disable iff (rst)
        wrCur |=> curVal == 24'h000000 && !zeroFlag)
        else $error("current write did not clear count and flag");
    a_no_pend_on_clear: assert property (@(posedge mclk) disable iff (rst)
        wrCur |=> !tickPend)
        else $error("tick pended by current write");
    a_zero_sets_flag: assert property (@(posedge mclk) disable iff (rst)
        (hitZero && !wrCur) |=> zeroFlag && curVal == 24'h000000)
        else $error("zero arrival did not set flag");
    a_read_clears: assert property (@(posedge mclk) disable iff (rst)
        (rdCtrl && !hitZero && !wrCur) |=> !zeroFlag)
        else $error("control read did not clear flag");
    a_wrap_reload: assert property (@(posedge mclk) disable iff (rst)
        (step && !wrCur && curVal == 24'h000000) |=> curVal == $past(reloadVal))
        else $error("counter did not reload");
    a_halt_holds: assert property (@(posedge mclk) disable iff (rst)
        (debugHalt && !wrCur) |=> $stable(curVal))
        else $error("counter moved during halt");
    a_disabled_holds: assert property (@(posedge mclk) disable iff (rst)
        (!ctrl[`STT_BIT_ENABLE] && !wrCur) |=> $stable(curVal) && !tickPend)
        else $error("disabled counter changed");
    a_pend_gated: assert property (@(posedge mclk) disable iff (rst)
        tickPend |-> $past(ctrl[`STT_BIT_TICK_IRQ_ENABLE]) && zeroFlag)
        else $error("tick pended without enable");
    a_decrement: assert property (@(posedge mclk) disable iff (rst)
        (step && !wrCur && curVal != 24'h000000) |=> curVal == $past(curVal) - 24'h000001)
        else $error("counter did not decrement");
    a_read_current: assert property (@(posedge mclk) disable iff (rst)
        (rdStb && addr == `STT_OFS_CURRENT) |=> rdData == {8'h00, $past(curVal)})
        else $error("current read mismatch");
    c_tick: cover property (@(posedge mclk) disable iff (rst) tickPend);
    c_wrap: cover property (@(posedge mclk) disable iff (rst) step && curVal == 24'h000000);
    c_halt: cover property (@(posedge mclk) disable iff (rst) debugHalt && ctrl[`STT_BIT_ENABLE]);
endmodule
`default_nettype wire

// [testbench/tb.sv]
// self-checking testbench for the system tick timer
`default_nettype none
`include "stt_consts.svh"
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk, rst, wrStb, rdStb, debugHalt, extRefTick, tickPend;
    logic [`STT_ADDR_W-1:0] addr;
    logic [31:0] wrData, rdData, d, v;
    int failures, compares, n;
    stt_timer i_stt_timer (.mclk(mclk), .rst(rst), .addr(addr), .wrData(wrData), .wrStb(wrStb),
        .rdStb(rdStb), .rdData(rdData), .debugHalt(debugHalt), .extRefTick(extRefTick), .tickPend(tickPend));
    // 125 MHz core clock
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    // ==========================================
    // bus and compare helpers
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic finish_test();
        $display("failures %0d compares %0d", failures, compares);
        if (failures == 0 && compares > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] x);
        @(posedge mclk);
        addr <= a;
        wrData <= x;
        wrStb <= 1'b1;
        @(posedge mclk);
        wrStb <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a);
        @(posedge mclk);
        addr <= a;
        rdStb <= 1'b1;
        @(posedge mclk);
        rdStb <= 1'b0;
        #1 d = rdData;
    endtask
    // cycles up to the next tick pulse, bounded
    task automatic gap(input int lim);
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (tickPend !== 1'b1 && n < lim);
        if (tickPend !== 1'b1) begin
            failures++;
            finish_test();
        end
    endtask
    // counts tick pulses over a stretch of cycles
    task automatic quiet(input int cyc);
        n = 0;
        repeat (cyc) begin
            @(posedge mclk);
            if (tickPend !== 1'b0) n++;
        end
    endtask
    // ==========================================
    // scenarios
    task automatic t_reset();
        logic [3:0] a[5] = '{4'h0, 4'h4, 4'h8, 4'hC, 4'h3};
        foreach (a[i]) begin
            rd(a[i]);
            check(d, 32'h0);
        end
    endtask
    task automatic t_period();
        wr(4'h4, 32'hFF000003);
        rd(4'h4);
        check(d, 32'h3);
        wr(4'h0, 32'h7);
        gap(60);
        gap(60);
        check(n, 4);
        debugHalt <= 1'b1;
        rd(4'h8);
        v = d;
        quiet(10);
        check(n, 0);
        rd(4'h8);
        check(d, v);
        wr(4'h8, 32'h5A);
        rd(4'h0);
        check(d, 32'h7);
        rd(4'h8);
        check(d, 32'h0);
        debugHalt <= 1'b0;
        quiet(3);
        check(n, 0);
        gap(20);
        debugHalt <= 1'b1;
        rd(4'h0);
        check(d, 32'h10007);
        rd(4'h0);
        check(d, 32'h7);
    endtask
    task automatic t_disable();
        debugHalt <= 1'b0;
        wr(4'h0, 32'h6);
        rd(4'h0);
        rd(4'h8);
        v = d;
        quiet(20);
        check(n, 0);
        rd(4'h8);
        check(d, v);
        rd(4'h0);
        check(d, 32'h6);
    endtask
    task automatic t_extclk();
        wr(4'h4, 32'h1);
        extRefTick <= 1'b1;
        wr(4'h0, 32'h3);
        gap(100);
        gap(100);
        check(n, 8);
        extRefTick <= 1'b0;
        quiet(40);
        check(n, 0);
    endtask
    task automatic t_zero();
        wr(4'h4, 32'h0);
        wr(4'h0, 32'h7);
        quiet(10);
        quiet(30);
        check(n, 0);
        rd(4'h8);
        check(d, 32'h0);
    endtask
    // reset, then the scenarios in turn
    initial begin
        rst = 1'b1;
        wrStb = 1'b0;
        rdStb = 1'b0;
        addr = 4'h0;
        wrData = 32'h0;
        debugHalt = 1'b0;
        extRefTick = 1'b0;
        failures = 0;
        compares = 0;
        repeat (20) @(posedge mclk);
        rst <= 1'b0;
        t_reset();
        t_period();
        t_disable();
        t_extclk();
        t_zero();
        finish_test();
    end
endmodule
`default_nettype wire
